// File: hw/sdp_regs.sv
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/100ps
module sdp_regs (
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  input  wire logic [3:0]                   addr,
  input  wire logic [31:0]                  wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [31:0]                  rdata,
  output logic                              variable_modulus,
  output logic      [sdp_pkg::SDP_INT_W-1:0] int_value,
  output logic      [sdp_pkg::SDP_FR1_W-1:0] primary_fraction_word,
  output logic      [sdp_pkg::SDP_FR2_W-1:0] auxiliary_fraction_word,
  output logic                              modulator_dither_enable,
  output logic      [sdp_pkg::SDP_PH_W-1:0]  phase_offset,
  output logic                              update_pulse
);
  import sdp_pkg::*;
  // -----------------------------------------------------------
  // decode
  // -----------------------------------------------------------
  // index comes from the low nibble of the word itself
  wire [3:0] widx     = wdata[SDP_IDX_MSB:SDP_IDX_LSB];
  wire       wr_int   = wr && (widx == SDP_IDX_INT);
  wire       wr_fr1   = wr && (widx == SDP_IDX_FR1);
  wire       wr_phase = wr && (widx == SDP_IDX_PHASE);
  wire       wr_fr2   = wr && (widx == SDP_IDX_FR2);
  // -----------------------------------------------------------
  // shadow storage
  // -----------------------------------------------------------
  logic [SDP_FR1_W-1:0] fr1_sh_q;
  logic                 dith_sh_q;
  logic [SDP_FR2_W-1:0] fr2_sh_q;
  logic [SDP_PH_W-1:0]  ph_sh_q;
  logic                 phen_sh_q;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      fr1_sh_q  <= '0;
      dith_sh_q <= 1'b0;
      fr2_sh_q  <= '0;
      ph_sh_q   <= SDP_PH_RST;
      phen_sh_q <= 1'b0;
    end
    else
    begin
      if (wr_fr1)
      begin
        fr1_sh_q  <= wdata[SDP_FR1_MSB:SDP_FR1_LSB];
        dith_sh_q <= wdata[SDP_DITH_BIT];
      end
      if (wr_fr2)
        fr2_sh_q <= wdata[SDP_FR2_MSB:SDP_FR2_LSB];
      if (wr_phase)
      begin
        ph_sh_q   <= wdata[SDP_PH_MSB:SDP_PH_LSB];
        phen_sh_q <= wdata[SDP_PHEN_BIT];
      end
    end
  end
  // -----------------------------------------------------------
  // active settings, loaded only by an integer write
  // -----------------------------------------------------------
  logic                 mode_q;
  logic [SDP_INT_W-1:0] int_q;
  logic [SDP_FR1_W-1:0] fr1_q;
  logic                 dith_q;
  logic [SDP_FR2_W-1:0] fr2_q;
  logic                 upd_q;
  logic [31:0]          rdata_q;
  // fixed modulus forces the auxiliary word out of the computation
  wire [SDP_FR2_W-1:0]  fr2_eff = wdata[SDP_MODE_BIT] ? fr2_sh_q : '0;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= 1'b0;
      int_q  <= '0;
      fr1_q  <= '0;
      dith_q <= 1'b0;
      fr2_q  <= '0;
      upd_q  <= 1'b0;
    end
    else
    begin
      upd_q <= wr_int;
      if (wr_int)
      begin
        mode_q <= wdata[SDP_MODE_BIT];
        int_q  <= wdata[SDP_INT_MSB:SDP_INT_LSB];
        fr1_q  <= fr1_sh_q;
        dith_q <= dith_sh_q;
        fr2_q  <= fr2_eff;
      end
    end
  end
  // -----------------------------------------------------------
  // phase adjust
  // -----------------------------------------------------------
  // steps only at integer write; disabled adjust leaves phase alone
  wire ph_step = wr_int && phen_sh_q;
  sdp_phase_acc #(
    .W (SDP_PH_W)
  ) u_phase (
    .ref_clk (ref_clk),
    .reset   (reset),
    .step    (ph_step),
    .amount  (ph_sh_q),
    .phase   (phase_offset)
  );
  // -----------------------------------------------------------
  // readback of active state, plus the shadow phase enable at the status index
  // -----------------------------------------------------------
  wire [31:0] rd_mux =
    (addr == SDP_IDX_INT)   ? {3'h0, mode_q, 8'h00, int_q, 4'h0}
  : (addr == SDP_IDX_FR1)   ? {dith_q, 2'h0, fr1_q, 4'h0}
  : (addr == SDP_IDX_PHASE) ? {16'h0000, phase_offset, 4'h0}
  : (addr == SDP_IDX_FR2)   ? {4'h0, fr2_q, 4'h0}
  : (addr == SDP_IDX_STAT)  ? {31'h0000_0000, phen_sh_q}
  : SDP_WORD_RST;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      rdata_q <= SDP_WORD_RST;
    else if (rd)
      rdata_q <= rd_mux;
    else
      rdata_q <= SDP_WORD_RST;
  end
  assign rdata                   = rdata_q;
  assign variable_modulus        = mode_q;
  assign int_value               = int_q;
  assign primary_fraction_word   = fr1_q;
  assign auxiliary_fraction_word = fr2_q;
  assign modulator_dither_enable = dith_q;
  assign update_pulse            = upd_q;
endmodule : sdp_regs

// File: hw/sdp_pkg.sv
// Summary of operation
// - active frequency changes only when the integer divide register is written
// - integer word bit 28: zero fixed 25-bit modulus, one variable modulus
// - integer divide value sits in bits 19 down to 4
// - primary fraction word bit 31 enables modulator dither
// - primary fraction word sits in bits 28 down to 4
// - fixed modulus uses the primary fraction field as the whole fraction
// - phase word bit 31 enables a relative phase advance
// - an enabled phase advance applies at every integer write while it stays enabled
// - phase advance equals value times 360 degrees over 2 to the 12th
// - phase value is 12 bits, held in bits 15 down to 4
// - auxiliary fraction word sits in bits 27 down to 4
// - fixed modulus ignores the auxiliary fraction word
package sdp_pkg;
  // -----------------------------------------------------------
  // register indices
  // -----------------------------------------------------------
  localparam logic [3:0] SDP_IDX_INT   = 4'h0;
  localparam logic [3:0] SDP_IDX_FR1   = 4'h1;
  localparam logic [3:0] SDP_IDX_PHASE = 4'h2;
  localparam logic [3:0] SDP_IDX_FR2   = 4'h3;
  localparam logic [3:0] SDP_IDX_STAT  = 4'hE;
  // -----------------------------------------------------------
  // field layout
  // -----------------------------------------------------------
  localparam int SDP_IDX_LSB   = 0;
  localparam int SDP_IDX_MSB   = 3;
  localparam int SDP_MODE_BIT  = 28;
  localparam int SDP_INT_MSB   = 19;
  localparam int SDP_INT_LSB   = 4;
  localparam int SDP_DITH_BIT  = 31;
  localparam int SDP_FR1_MSB   = 28;
  localparam int SDP_FR1_LSB   = 4;
  localparam int SDP_PHEN_BIT  = 31;
  localparam int SDP_PH_MSB    = 15;
  localparam int SDP_PH_LSB    = 4;
  localparam int SDP_FR2_MSB   = 27;
  localparam int SDP_FR2_LSB   = 4;
  localparam int SDP_INT_W     = 16;
  localparam int SDP_FR1_W     = 25;
  localparam int SDP_FR2_W     = 24;
  localparam int SDP_PH_W      = 12;
  // -----------------------------------------------------------
  // reset values
  // -----------------------------------------------------------
  localparam logic [31:0] SDP_WORD_RST = 32'h0000_0000;
  localparam logic [SDP_PH_W-1:0] SDP_PH_RST = 12'h000;
endpackage : sdp_pkg

// File: hw/sdp_phase_acc.sv
`timescale 1ns/100ps
module sdp_phase_acc #(
  parameter int W = 12
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         step,
  input  wire logic [W-1:0] amount,
  output logic      [W-1:0] phase
);
  import sdp_pkg::*;
  logic [W-1:0] phase_q;
  // modulo 2^W wraps naturally: full circle is 360 degrees
  wire [W-1:0] phase_d = W'(phase_q + amount);
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      phase_q <= '0;
    else if (step)
      phase_q <= phase_d;
  end
  assign phase = phase_q;
endmodule : sdp_phase_acc

// File: sim/sdp_checker.sv
`timescale 1ns/100ps
module sdp_checker (
  input wire logic        ref_clk, reset, wr, rd, variable_modulus,
  input wire logic        modulator_dither_enable, update_pulse,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata, rdata,
  input wire logic [15:0] int_value,
  input wire logic [24:0] primary_fraction_word,
  input wire logic [23:0] auxiliary_fraction_word,
  input wire logic [11:0] phase_offset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire iw = wr && (wdata[3:0] == 4'h0);
  sequence s_int; iw; endsequence
  a_upd_after_int: assert property (s_int |=> update_pulse)
    else $error("no update after integer write");
  a_upd_cause: assert property (update_pulse |-> $past(iw))
    else $error("update without integer write");
  a_hold_int: assert property (!update_pulse |-> $stable(int_value)
    && $stable(primary_fraction_word)) else $error("active word moved");
  a_hold_phase: assert property (!update_pulse |-> $stable(phase_offset))
    else $error("phase moved without update");
  a_int_field: assert property (s_int |=> int_value == $past(wdata[19:4]))
    else $error("integer field wrong");
  a_mode_bit: assert property (s_int |=> variable_modulus == $past(wdata[28]))
    else $error("mode bit wrong");
  a_fixed_aux: assert property (iw && !wdata[28] |=> auxiliary_fraction_word == 24'h0)
    else $error("aux word used in fixed mode");
  a_rd_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
  a_rd_int: assert property (rd && addr == 4'h0 |=> rdata[19:4] == $past(int_value))
    else $error("readback wrong");
endmodule : sdp_checker
bind sdp_regs sdp_checker u_chk (.*);

// File: sim/sdp_host.sv
`timescale 1ns/100ps
module sdp_host (
  input  wire logic        ref_clk,
  input  wire logic [31:0] rdata,
  output logic             wr, rd,
  output logic [3:0]       addr,
  output logic [31:0]      wdata
);
  initial {wr, rd, addr, wdata} = 38'h0;
  // the index travels in the word itself
  task put(input logic [31:0] w);
    @(posedge ref_clk);
    wr <= 1'b1;
    wdata <= w;
  endtask : put
  task idle;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : idle
  task get(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    // read data stand only in the cycle after the strobe: take them once settled
    #1 d = rdata;
  endtask : get
endmodule : sdp_host

// File: sim/tb_sdp_regs.sv
`timescale 1ns/100ps
module tb_sdp_regs;
  import sdp_pkg::*;
  logic                 ref_clk, reset, wr, rd, update_pulse;
  logic                 variable_modulus, modulator_dither_enable;
  logic [3:0]           addr;
  logic [31:0]          wdata, rdata, d;
  logic [SDP_INT_W-1:0] int_value;
  logic [SDP_FR1_W-1:0] primary_fraction_word;
  logic [SDP_FR2_W-1:0] auxiliary_fraction_word;
  logic [SDP_PH_W-1:0]  phase_offset;
  int                   fails, num_checks;
  sdp_regs dut (.*);
  sdp_host host (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task acts(input logic [31:0] iv, fr, ax, ph, input logic vm, dt);
    chk("int", int_value, iv);
    chk("prim fraction", primary_fraction_word, fr);
    chk("aux fraction", auxiliary_fraction_word, ax);
    chk("phase", phase_offset, ph);
    chk("mode", variable_modulus, vm);
    chk("dither", modulator_dither_enable, dt);
    $display("test step done");
  endtask : acts
  initial
  begin
    #20000 fails++;
    give_verdict;
  end
  initial
  begin
    fails = 0;
    num_checks = 0;
    reset = 1'b1;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    #1 acts(0, 0, 0, 0, 0, 0);
    host.put(32'h9ABC_DEF1);
    host.put(32'h8000_2002);
    host.put(32'h0C0F_FEE3);
    host.idle;
    #1 acts(0, 0, 0, 0, 0, 0);
    host.put(32'h1000_0640);
    host.idle;
    #1 chk("upd", update_pulse, 1);
    acts(16'h64, 25'h1ABCDEF, 24'hC0FFEE, 12'h200, 1, 1);
    host.put(32'h0000_04B0);
    host.idle;
    #1 acts(16'h4B, 25'h1ABCDEF, 0, 12'h400, 0, 1);
    host.put(32'h0000_0002);
    host.put(32'hFFFF_FFF5);
    host.put(32'h0000_04B0);
    host.idle;
    #1 acts(16'h4B, 25'h1ABCDEF, 0, 12'h400, 0, 1);
    host.get(4'h0, d);
    chk("rd int", d, 32'h0000_04B0);
    host.get(4'h1, d);
    chk("rd prim fraction", d, 32'h9ABC_DEF0);
    host.get(4'h2, d);
    chk("rd phase", d, 32'h0000_4000);
    host.get(4'h3, d);
    chk("rd aux fraction", d, 32'h0000_0000);
    host.get(4'hE, d);
    chk("rd phase enable", d, 32'h0000_0000);
    host.get(4'h5, d);
    chk("rd unmapped", d, 0);
    $display("readback test done");
    give_verdict;
  end
endmodule : tb_sdp_regs
